/* File: logic/ipec_intc.v */
// Interrupt priority resolver with event code capture and APB registers
`timescale 1ns/1ps
`include "ipec_regs.vh"
module ipec_intc (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire nmiPin,
    input wire [3:0] extLevelPins_n,
    input wire debugIrq,
    input wire portIrq,
    input wire [7:0] dmaDoneIrq,
    input wire dmaAddrErrorIrq,
    input wire [4:0] timerIrq,
    input wire timerCaptureIrq,
    input wire [2:0] rtcIrq,
    input wire [3:0] serialIrq,
    input wire [3:0] fifoSerialIrq,
    input wire watchdogIrq,
    input wire [1:0] refreshIrq,
    input wire blockBit,
    input wire [3:0] srMaskLevel,
    input wire irqAccept,
    output reg irqRequest,
    output reg [4:0] irqLevel,
    output reg [11:0] eventCode
);
    localparam NSRC = 36;

    reg ctrl_reg;
    reg [15:0] prioA_reg;
    reg [15:0] prioB_reg;
    reg [15:0] prioC_reg;
    reg [15:0] prioD_reg;
    reg [7:0] extPrio_reg;
    reg [11:0] eventCode_reg;
    reg [2:0] nmiSync_reg;
    reg nmiStable_reg;
    reg nmiPend_reg;
    reg [3:0] irlS1_reg;
    reg [3:0] irlS2_reg;
    reg [3:0] irlS3_reg;
    reg [3:0] irlStable_reg;

    reg [NSRC-1:0] srcReq;
    reg [NSRC*5-1:0] srcLvl;
    reg [NSRC*12-1:0] srcCode;
    reg [4:0] winLvl;
    reg [11:0] winCode;
    reg winValid;
    reg winNmi;
    reg [31:0] readData;
    reg addrOk;
    integer i;
    integer k;

    wire setup = psel & ~penable;
    wire wrStrobe = psel & penable & pwrite & ~pslverr;
    wire pinMode = ctrl_reg;
    wire [3:0] irlCode = irlStable_reg;
    wire takeNow;
    // Edge counts only once stages two and three agree
    wire nmiAgree = (nmiSync_reg[1] == nmiSync_reg[2]);
    wire nmiEdge = nmiAgree && nmiSync_reg[2] && !nmiStable_reg;

    assign pready = 1'b1;

    function [4:0] fld;
        input [15:0] r;
        input [1:0] idx;
        begin
            fld = {1'b0, r[idx*4 +: 4]};
        end
    endfunction

    // Fixed default order: index 0 highest
    always @* begin
        srcReq = {NSRC{1'b0}};
        srcLvl = {NSRC*5{1'b0}};
        srcCode = {NSRC*12{1'b0}};
        srcReq[0] = nmiPend_reg;
        srcLvl[0 +: 5] = `IPEC_LVL_NMI;
        srcCode[0 +: 12] = `IPEC_CODE_NMI;
        if (pinMode) begin
            srcReq[4:1] = ~irlCode;
            srcLvl[5 +: 5] = fld(prioD_reg, 2'd3);
            srcLvl[10 +: 5] = fld(prioD_reg, 2'd2);
            srcLvl[15 +: 5] = fld(prioD_reg, 2'd1);
            srcLvl[20 +: 5] = fld(prioD_reg, 2'd0);
            srcCode[12 +: 12] = `IPEC_CODE_IRL0;
            srcCode[24 +: 12] = `IPEC_CODE_IRL1;
            srcCode[36 +: 12] = `IPEC_CODE_IRL2;
            srcCode[48 +: 12] = `IPEC_CODE_IRL3;
        end else begin
            srcReq[1] = (irlCode != `IPEC_IRL_NONE);
            srcLvl[5 +: 5] = {1'b0, `IPEC_LVL_IRL_TOP - irlCode};
            srcCode[12 +: 12] = `IPEC_CODE_IRL_BASE + {irlCode, 5'h00};
        end
        srcReq[5] = debugIrq;
        srcReq[6] = portIrq;
        srcReq[14:7] = dmaDoneIrq;
        srcReq[15] = dmaAddrErrorIrq;
        srcReq[17:16] = timerIrq[4:3];
        srcReq[20:18] = timerIrq[2:0];
        srcReq[21] = timerCaptureIrq;
        srcReq[24:22] = rtcIrq;
        srcReq[28:25] = serialIrq;
        srcReq[32:29] = fifoSerialIrq;
        srcReq[33] = watchdogIrq;
        srcReq[35:34] = refreshIrq;
        srcLvl[25 +: 5] = fld(prioC_reg, 2'd0);
        srcLvl[30 +: 5] = fld(prioC_reg, 2'd3);
        for (i = 7; i < 16; i = i + 1) begin
            srcLvl[i*5 +: 5] = fld(prioC_reg, 2'd2);
        end
        srcLvl[80 +: 5] = {1'b0, extPrio_reg[3:0]};
        srcLvl[85 +: 5] = {1'b0, extPrio_reg[7:4]};
        srcLvl[90 +: 5] = fld(prioA_reg, 2'd3);
        srcLvl[95 +: 5] = fld(prioA_reg, 2'd2);
        srcLvl[100 +: 5] = fld(prioA_reg, 2'd1);
        srcLvl[105 +: 5] = fld(prioA_reg, 2'd1);
        for (i = 22; i < 25; i = i + 1) begin
            srcLvl[i*5 +: 5] = fld(prioA_reg, 2'd0);
        end
        for (i = 25; i < 29; i = i + 1) begin
            srcLvl[i*5 +: 5] = fld(prioB_reg, 2'd1);
        end
        for (i = 29; i < 33; i = i + 1) begin
            srcLvl[i*5 +: 5] = fld(prioC_reg, 2'd1);
        end
        srcLvl[165 +: 5] = fld(prioB_reg, 2'd3);
        srcLvl[170 +: 5] = fld(prioB_reg, 2'd2);
        srcLvl[175 +: 5] = fld(prioB_reg, 2'd2);
        srcCode[60 +: 12] = `IPEC_CODE_DEBUG;
        srcCode[72 +: 12] = `IPEC_CODE_PORT;
        for (i = 0; i < 4; i = i + 1) begin
            srcCode[(7+i)*12 +: 12] = `IPEC_CODE_DMA_LO + `IPEC_CODE_STEP * i[11:0];
            srcCode[(11+i)*12 +: 12] = `IPEC_CODE_DMA_HI + `IPEC_CODE_STEP * i[11:0];
        end
        srcCode[180 +: 12] = `IPEC_CODE_DMA_ERR;
        srcCode[192 +: 12] = `IPEC_CODE_TMR3;
        srcCode[204 +: 12] = `IPEC_CODE_TMR4;
        for (i = 0; i < 4; i = i + 1) begin
            srcCode[(18+i)*12 +: 12] = `IPEC_CODE_TMR0 + `IPEC_CODE_STEP * i[11:0];
            srcCode[(25+i)*12 +: 12] = `IPEC_CODE_SER1 + `IPEC_CODE_STEP * i[11:0];
            srcCode[(29+i)*12 +: 12] = `IPEC_CODE_FSER + `IPEC_CODE_STEP * i[11:0];
        end
        for (i = 0; i < 3; i = i + 1) begin
            srcCode[(22+i)*12 +: 12] = `IPEC_CODE_RTC + `IPEC_CODE_STEP * i[11:0];
        end
        srcCode[396 +: 12] = `IPEC_CODE_WDT;
        srcCode[408 +: 12] = `IPEC_CODE_REF;
        srcCode[420 +: 12] = `IPEC_CODE_REF + `IPEC_CODE_STEP;
    end

    // Strictly greater replaces, so ties keep the earlier source
    always @* begin
        winLvl = 5'h00;
        winCode = `IPEC_RST_CODE;
        winNmi = 1'b0;
        for (k = 0; k < NSRC; k = k + 1) begin
            if (srcReq[k] && (srcLvl[k*5 +: 5] > winLvl)) begin
                winLvl = srcLvl[k*5 +: 5];
                winCode = srcCode[k*12 +: 12];
                winNmi = (k == 0);
            end
        end
        winValid = (winLvl != 5'h00);
    end

    assign takeNow = winValid && !blockBit && (winLvl > {1'b0, srMaskLevel});

    always @(posedge clk) begin
        if (rst) begin
            irqRequest <= 1'b0;
            irqLevel <= 5'h00;
        end else begin
            irqRequest <= takeNow;
            irqLevel <= winLvl;
        end
    end

    // Pin synchronisers: a change counts when stages two and three agree
    always @(posedge clk) begin
        if (rst) begin
            nmiSync_reg <= 3'b000;
            nmiStable_reg <= 1'b0;
            irlS1_reg <= `IPEC_IRL_NONE;
            irlS2_reg <= `IPEC_IRL_NONE;
            irlS3_reg <= `IPEC_IRL_NONE;
            irlStable_reg <= `IPEC_IRL_NONE;
        end else begin
            nmiSync_reg <= {nmiSync_reg[1:0], nmiPin};
            if (nmiAgree) begin
                nmiStable_reg <= nmiSync_reg[2];
            end
            irlS1_reg <= extLevelPins_n;
            irlS2_reg <= irlS1_reg;
            irlS3_reg <= irlS2_reg;
            if (irlS2_reg == irlS3_reg) begin
                irlStable_reg <= irlS3_reg;
            end
        end
    end

    // NMI edge latch; a new edge wins over the clear on acceptance
    always @(posedge clk) begin
        if (rst) begin
            nmiPend_reg <= 1'b0;
        end else if (nmiEdge) begin
            nmiPend_reg <= 1'b1;
        end else if (irqAccept && irqRequest && winNmi) begin
            nmiPend_reg <= 1'b0;
        end
    end

    // Acceptance: the code of whatever wins now, zero if it vanished or is masked or blocked.
    // The status mask is an input only and is never written here.
    always @(posedge clk) begin
        if (rst) begin
            eventCode_reg <= `IPEC_RST_CODE;
        end else if (irqAccept) begin
            eventCode_reg <= takeNow ? winCode : `IPEC_RST_CODE;
        end
    end

    always @* begin
        eventCode = eventCode_reg;
    end

    always @* begin
        readData = 32'h00000000;
        addrOk = 1'b1;
        case (paddr)
            `IPEC_OFF_CTRL: readData[`IPEC_BIT_PIN_MODE] = ctrl_reg;
            `IPEC_OFF_PRIO_A: readData[15:0] = prioA_reg;
            `IPEC_OFF_PRIO_B: readData[15:0] = prioB_reg;
            `IPEC_OFF_PRIO_C: readData[15:0] = prioC_reg;
            `IPEC_OFF_PRIO_D: readData[15:0] = prioD_reg;
            `IPEC_OFF_EXT_PRIO: readData[15:8] = extPrio_reg;
            `IPEC_OFF_EXT_SRC: readData[1:0] = timerIrq[4:3];
            `IPEC_OFF_EVENT: readData[11:0] = eventCode_reg;
            default: addrOk = 1'b0;
        endcase
    end

    // Read data and error are latched in the setup cycle
    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : readData;
            pslverr <= ~addrOk;
        end
    end

    // Writes land whatever the block bit; ordering is software's job
    always @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= 1'b0;
            prioA_reg <= `IPEC_RST_PRIO;
            prioB_reg <= `IPEC_RST_PRIO;
            prioC_reg <= `IPEC_RST_PRIO;
            prioD_reg <= `IPEC_RST_PRIO_D;
            extPrio_reg <= 8'h00;
        end else if (wrStrobe) begin
            case (paddr)
                `IPEC_OFF_CTRL: ctrl_reg <= pwdata[`IPEC_BIT_PIN_MODE];
                `IPEC_OFF_PRIO_A: prioA_reg <= pwdata[15:0];
                `IPEC_OFF_PRIO_B: prioB_reg <= pwdata[15:0];
                `IPEC_OFF_PRIO_C: prioC_reg <= pwdata[15:0];
                `IPEC_OFF_PRIO_D: prioD_reg <= pwdata[15:0];
                `IPEC_OFF_EXT_PRIO: extPrio_reg <= pwdata[15:8];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end
endmodule // ipec_intc

/* File: logic/ipec_regs.vh */
// Register offsets, field positions, reset values and event codes of the interrupt resolver
`ifndef IPEC_REGS_VH
`define IPEC_REGS_VH
`define IPEC_OFF_CTRL 12'h000
`define IPEC_OFF_PRIO_A 12'h004
`define IPEC_OFF_PRIO_B 12'h008
`define IPEC_OFF_PRIO_C 12'h00c
`define IPEC_OFF_PRIO_D 12'h010
`define IPEC_OFF_EXT_PRIO 12'h020
`define IPEC_OFF_EXT_SRC 12'h024
`define IPEC_OFF_EVENT 12'h028
`define IPEC_RST_PRIO 16'h0000
`define IPEC_RST_PRIO_D 16'hda74
`define IPEC_RST_CODE 12'h000
`define IPEC_BIT_PIN_MODE 0
`define IPEC_LVL_NMI 5'h10
`define IPEC_LVL_IRL_TOP 4'hf
`define IPEC_IRL_NONE 4'hf
`define IPEC_CODE_NMI 12'h1c0
`define IPEC_CODE_IRL_BASE 12'h200
`define IPEC_CODE_IRL_STEP 12'h020
`define IPEC_CODE_IRL0 12'h240
`define IPEC_CODE_IRL1 12'h2a0
`define IPEC_CODE_IRL2 12'h300
`define IPEC_CODE_IRL3 12'h360
`define IPEC_CODE_DEBUG 12'h600
`define IPEC_CODE_PORT 12'h620
`define IPEC_CODE_DMA_LO 12'h640
`define IPEC_CODE_DMA_HI 12'h780
`define IPEC_CODE_DMA_ERR 12'h6c0
`define IPEC_CODE_TMR3 12'hb00
`define IPEC_CODE_TMR4 12'hb80
`define IPEC_CODE_TMR0 12'h400
`define IPEC_CODE_RTC 12'h480
`define IPEC_CODE_SER1 12'h4e0
`define IPEC_CODE_FSER 12'h700
`define IPEC_CODE_WDT 12'h560
`define IPEC_CODE_REF 12'h580
`define IPEC_CODE_STEP 12'h020
`endif

/* File: sim/ipec_intc_sva.sv */
// Port-level checks of the interrupt resolver, bound to its top module
`timescale 1ns/1ps
module ipec_intc_sva (
    input wire clk,
    input wire rst,
    input wire nmiPin,
    input wire blockBit,
    input wire [3:0] srMaskLevel,
    input wire irqAccept,
    input wire irqRequest,
    input wire [4:0] irqLevel,
    input wire [11:0] eventCode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_take_rule: assert property (
        irqRequest == (irqLevel > {1'h0, $past(srMaskLevel)} && !$past(blockBit)))
        else $error("request flag wrong");
    a_idle_level: assert property (irqLevel == 5'h00 |-> !irqRequest)
        else $error("request without level");
    a_level_top: assert property (irqLevel <= 5'h10)
        else $error("level above sixteen");
    a_block_quiet: assert property (blockBit [*2] |-> !irqRequest)
        else $error("request while blocked");
    a_nmi_code: assert property (
        irqAccept && !blockBit && irqLevel == 5'h10 |=> eventCode == 12'h1c0)
        else $error("wrong nmi code");
    a_code_hold: assert property (!irqAccept |=> $stable(eventCode))
        else $error("code moved without accept");
    a_code_align: assert property (eventCode[4:0] == 5'h00)
        else $error("code off its step");
    a_nmi_seen: assert property ($rose(nmiPin) |-> ##[1:8] irqLevel == 5'h10)
        else $error("nmi not pending");
    c_taken: cover property (irqAccept && irqRequest);
    c_nmi: cover property (irqLevel == 5'h10);
    c_blocked: cover property (blockBit && irqLevel != 5'h00);
    c_zero_code: cover property (irqAccept ##1 eventCode == 12'h000);
endmodule // ipec_intc_sva
bind ipec_intc ipec_intc_sva i_sva (.clk(clk), .rst(rst), .nmiPin(nmiPin), .blockBit(blockBit),
    .srMaskLevel(srMaskLevel), .irqAccept(irqAccept), .irqRequest(irqRequest),
    .irqLevel(irqLevel), .eventCode(eventCode));

/* File: sim/ipec_cpu_model.sv */
// CPU exception side: takes a request, then stays blocked until return
`timescale 1ns/1ps
module ipec_cpu_model (
    input wire clk,
    input wire rst,
    input wire irqRequest,
    input wire swBlock,
    input wire return_from_exception,
    input wire [1:0] hold,
    output reg irqAccept,
    output wire blockBit
);
    reg taken_reg;
    reg [1:0] wait_reg;
    assign blockBit = swBlock | taken_reg;
    always @(posedge clk) begin
        wait_reg <= (!rst && irqRequest && !blockBit) ? wait_reg + 2'h1 : 2'h0;
        irqAccept <= !rst && irqRequest && !blockBit && !irqAccept && wait_reg >= hold;
        taken_reg <= !rst && !return_from_exception && (taken_reg || irqAccept);
    end
endmodule // ipec_cpu_model

/* File: sim/test_interrupt_priority_event_code.sv */
// Random and corner stimulus for the interrupt resolver
`timescale 1ns/1ps
`include "ipec_regs.vh"
module test_interrupt_priority_event_code;
    reg clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg nmi = 1'h0, swBlock = 1'h0, return_from_exception = 1'h0, err;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [3:0] pins_n = 4'hf, mask = 4'h0;
    reg [1:0] hold = 2'h0;
    reg [30:0] src = 31'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irqAccept, irqRequest, blockBit;
    wire [4:0] irqLevel;
    wire [11:0] eventCode;
    integer seed = 88795, fail_count = 0, check_count = 0, i, j, k, lvl, n;
    always #2.5 clk = ~clk;
    ipec_intc i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nmiPin(nmi), .extLevelPins_n(pins_n), .debugIrq(src[0]), .portIrq(src[1]),
        .dmaDoneIrq(src[9:2]), .dmaAddrErrorIrq(src[10]), .timerIrq(src[15:11]),
        .timerCaptureIrq(src[16]), .rtcIrq(src[19:17]), .serialIrq(src[23:20]),
        .fifoSerialIrq(src[27:24]), .watchdogIrq(src[28]), .refreshIrq(src[30:29]),
        .blockBit(blockBit), .srMaskLevel(mask), .irqAccept(irqAccept),
        .irqRequest(irqRequest), .irqLevel(irqLevel), .eventCode(eventCode));
    ipec_cpu_model i_cpu (.clk(clk), .rst(rst), .irqRequest(irqRequest), .swBlock(swBlock),
        .return_from_exception(return_from_exception), .hold(hold), .irqAccept(irqAccept), .blockBit(blockBit));
    function [11:0] codeOf(input integer x);
        if (x < 2) codeOf = 12'h600 + 12'(32 * x);
        else if (x < 6) codeOf = 12'h640 + 12'(32 * (x - 2));
        else if (x < 10) codeOf = 12'h780 + 12'(32 * (x - 6));
        else if (x == 10) codeOf = 12'h6c0;
        else if (x < 14) codeOf = 12'h400 + 12'(32 * (x - 11));
        else if (x < 16) codeOf = 12'hb00 + 12'(128 * (x - 14));
        else if (x < 20) codeOf = 12'h460 + 12'(32 * (x - 16));
        else if (x < 24) codeOf = 12'h4e0 + 12'(32 * (x - 20));
        else if (x < 28) codeOf = 12'h700 + 12'(32 * (x - 24));
        else codeOf = 12'h560 + 12'(32 * (x - 28));
    endfunction
    function integer rank(input integer x);
        rank = (x > 10 && x < 14) ? x + 2 : (x == 14 || x == 15) ? x - 3 : x;
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task guard(input ok);
        if (!ok) begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (pready !== 1'h1 && n < 20);
        guard(pready === 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task setAll(input [3:0] l);
        swBlock <= 1'h1;
        for (k = 0; k < 3; k = k + 1)
            apb(1'h1, `IPEC_OFF_PRIO_A + 12'(4 * k), {16'h0, {4{l}}});
        apb(1'h1, `IPEC_OFF_EXT_PRIO, {16'h0, l, l, 8'h00});
        apb(1'h0, `IPEC_OFF_PRIO_C, 32'h0);
        check(rd, {16'h0, {4{l}}});
        swBlock <= 1'h0;
    endtask
    task take(input [11:0] code, input [4:0] l);
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (irqAccept !== 1'h1 && n < 60);
        guard(irqAccept === 1'h1);
        check(irqLevel, l);
        @(negedge clk);
        check(eventCode, code);
        @(posedge clk);
        src <= 31'h0;
        nmi <= 1'h0;
        pins_n <= 4'hf;
        apb(1'h0, `IPEC_OFF_EXT_SRC, 32'h0);
        apb(1'h0, `IPEC_OFF_EVENT, 32'h0);
        check(rd, {20'h0, code});
        repeat (6) @(posedge clk);
        return_from_exception <= 1'h1;
        @(posedge clk);
        return_from_exception <= 1'h0;
    endtask
    task quiet;
        repeat (12) @(posedge clk);
        @(negedge clk);
        check(irqRequest, 1'h0);
        @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (j = 0; j < 4; j = j + 1) begin
            apb(1'h0, `IPEC_OFF_PRIO_A + 12'(4 * j), 32'h0);
            check(rd, j == 3 ? {16'h0, `IPEC_RST_PRIO_D} : 32'h0);
        end
        apb(1'h1, 12'h0fc, 32'h0);
        check({31'h0, err}, 32'h1);
        src <= 31'h7fffffff;
        quiet;
        $display("Reset test done");
        for (j = 0; j < 31; j = j + 1) begin
            lvl = 1 + $unsigned($random(seed)) % 15;
            setAll(4'(lvl));
            mask <= 4'($unsigned($random(seed)) % lvl);
            hold <= 2'($random(seed));
            src <= 31'h1 << j;
            take(codeOf(j), 5'(lvl));
        end
        for (j = 0; j < 30; j = j + 1) begin
            i = $unsigned($random(seed)) % 31;
            k = $unsigned($random(seed)) % 31;
            src <= (31'h1 << i) | (31'h1 << k);
            take(codeOf(rank(i) < rank(k) ? i : k), 5'(lvl));
        end
        $display("Source test done");
        mask <= 4'(lvl);
        src <= 31'h1;
        quiet;
        mask <= 4'h0;
        swBlock <= 1'h1;
        src <= 31'h2;
        quiet;
        nmi <= 1'h1;
        src <= 31'h1;
        repeat (8) @(posedge clk);
        swBlock <= 1'h0;
        take(`IPEC_CODE_NMI, 5'h10);
        hold <= 2'h1;
        src <= 31'h1;
        repeat (2) @(posedge clk);
        src <= 31'h0;
        take(`IPEC_RST_CODE, 5'h00);
        $display("Mask test done");
        for (j = 0; j < 15; j = j + 1) begin
            pins_n <= 4'(j);
            take(12'h200 + 12'(32 * j), 5'(15 - j));
        end
        swBlock <= 1'h1;
        apb(1'h1, `IPEC_OFF_CTRL, 32'h1);
        swBlock <= 1'h0;
        for (j = 0; j < 4; j = j + 1) begin
            pins_n <= ~(4'h1 << j);
            take(12'h240 + 12'(96 * j), 5'(13 - 3 * j));
        end
        $display("Pin test done");
        tally_and_finish;
    end
endmodule // test_interrupt_priority_event_code
